// >>> design/adc_bias_channel_config_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Bias register at 0x3B, reset zero, bias bits 6-4, full-scale bits 1-0.
// - Bias codes pick reference, 1.096x reference, common mode, supply, or general input two.
// - Codes 2,3,4 take common mode from negative input 1, 2, or their average.
// - Full-scale codes give 2.75, 2.5, 1.375 V; code 3 reserved.
// - Reserved bits read zero; host writes only zero there.
// - Input register at 0x3C, reset zero; bit 7 picks microphone or line.
// - Source bits 6-5: differential, single-ended, pulse microphone; code 3 reserved.
// - Bit 4 picks AC or DC coupling, analog inputs only.
// - Impedance bits 3-2: 2.5k, 10k, 20k; code 3 reserved.
// - Bit 0 enables enhancer, gain control or compressor chosen by register 108 bit 3.
// - Gain register at 0x3D, reset zero, gain bits 7-1, sign bit 0.
// - Gain in 0.5 dB steps to code 84; codes 85-127 reserved.
// - Sign bit gives negative gain, only with 10k or 20k impedance.
module adc_bias_channel_config_regs
  import adc_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Two-wire control port, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Selector from register 108 bit 3
  input wire logic page0_reg108_sel_i,
  // Bias and full-scale controls
  output logic [2:0] bias_source_select_o,
  output logic [1:0] common_mode_level_src_o,
  output logic general_input_two_mode_o,
  output logic [1:0] full_scale_select_o,
  // Channel 1 controls
  output logic chan1_input_type_o,
  output logic [1:0] chan1_source_select_o,
  output logic chan1_coupling_o,
  output logic [1:0] chan1_impedance_o,
  output logic range_enhancer_en_o,
  output logic auto_gain_control_en_o,
  output logic [6:0] chan1_gain_field_o,
  output logic chan1_gain_negative_o
);
  logic scl_s;
  logic sda_s;
  logic scl_q_r;
  logic sda_q_r;
  port_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic first_r, first_nxt;
  logic nack_r, nack_nxt;
  bias_cfg_t bias_r, bias_nxt;
  chan1_cfg0_t cfg0_r, cfg0_nxt;
  chan1_cfg1_t cfg1_r, cfg1_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic wr_en;
  logic [7:0] rd_data;

  // Pins are asynchronous to clk_i
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_scl (.clk_i(clk_i), .rst_i(rst_i), .async_i(scl_i), .sync_o(scl_s));
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_sda (.clk_i(clk_i), .rst_i(rst_i), .async_i(sda_i), .sync_o(sda_s));

  // Edge and framing detection on synchronised pins
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // Read mux; reserved bits are held zero in storage
  always_comb begin
    case (ptr_r)
      BIAS_FULLSCALE_CONFIG_OFS: rd_data = bias_r;
      CHAN1_INPUT_CONFIG_OFS: rd_data = cfg0_r;
      CHAN1_GAIN_CONFIG_OFS: rd_data = cfg1_r;
      default: rd_data = UNMAPPED_READ_VAL;
    endcase
  end

  // Data byte completes on the falling clock after its eighth bit
  assign wr_en = (state_r == ST_WR_BYTE) && scl_fall && (cnt_r == BITS_PER_BYTE) && !first_r;

  // Port sequencer and register next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    nack_nxt = nack_r;
    bias_nxt = bias_r;
    cfg0_nxt = cfg0_r;
    cfg1_nxt = cfg1_r;
    case (state_r)
      ST_ADDR, ST_WR_BYTE: begin
        if (scl_rise) begin
          shift_nxt = {shift_r[6:0], sda_s};
          cnt_nxt = cnt_r + 4'h1;
        end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
          cnt_nxt = '0;
          if (state_r == ST_ADDR) begin
            rw_nxt = shift_r[0];
            state_nxt = (shift_r[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
          end else begin
            state_nxt = ST_ACK_WR;
            if (first_r) begin
              ptr_nxt = shift_r;
              first_nxt = 1'b0;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
      end
      ST_ACK_ADDR: begin
        if (scl_fall) begin
          if (rw_r) begin
            tx_nxt = rd_data;
            ptr_nxt = ptr_r + 8'h01;
            state_nxt = ST_RD_BYTE;
          end else begin
            first_nxt = 1'b1;
            state_nxt = ST_WR_BYTE;
          end
        end
      end
      ST_ACK_WR: begin
        if (scl_fall) begin
          state_nxt = ST_WR_BYTE;
        end
      end
      ST_RD_BYTE: begin
        if (scl_fall) begin
          if (cnt_r == LAST_READ_BIT) begin
            cnt_nxt = '0;
            state_nxt = ST_ACK_RD;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
            tx_nxt = {tx_r[6:0], 1'b0};
          end
        end
      end
      ST_ACK_RD: begin
        if (scl_rise) begin
          nack_nxt = sda_s;
        end else if (scl_fall) begin
          if (nack_r) begin
            state_nxt = ST_IDLE;
          end else begin
            tx_nxt = rd_data;
            ptr_nxt = ptr_r + 8'h01;
            state_nxt = ST_RD_BYTE;
          end
        end
      end
      ST_IDLE: begin
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (wr_en) begin
      case (ptr_r)
        BIAS_FULLSCALE_CONFIG_OFS: begin
          bias_nxt.bias_source_select = shift_r[6:4];
          bias_nxt.full_scale_select = shift_r[1:0];
        end
        CHAN1_INPUT_CONFIG_OFS: begin
          cfg0_nxt.chan1_input_type = shift_r[7];
          cfg0_nxt.chan1_source_select = shift_r[6:5];
          cfg0_nxt.chan1_coupling = shift_r[4];
          cfg0_nxt.chan1_impedance = shift_r[3:2];
          cfg0_nxt.chan1_range_enhance_enable = shift_r[0];
        end
        // gain stored as written, legal range up to the host
        CHAN1_GAIN_CONFIG_OFS: begin
          cfg1_nxt = shift_r;
        end
        default: begin
          bias_nxt = bias_r;
        end
      endcase
    end
    bias_nxt.rsv7 = 1'b0;
    bias_nxt.rsv32 = 2'h0;
    cfg0_nxt.rsv1 = 1'b0;
    // Start restarts framing from any state, stop ends it
    if (start_det) begin
      state_nxt = ST_ADDR;
      cnt_nxt = '0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      state_r <= ST_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      ptr_r <= '0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      bias_r <= REG_RESET_VAL;
      cfg0_r <= REG_RESET_VAL;
      cfg1_r <= REG_RESET_VAL;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      nack_r <= nack_nxt;
      bias_r <= bias_nxt;
      cfg0_r <= cfg0_nxt;
      cfg1_r <= cfg1_nxt;
    end
  end

  // Open drain: pull low to acknowledge or send a zero
  assign sda_o = 1'b0;
  assign sda_oe_o = (state_r == ST_ACK_ADDR) || (state_r == ST_ACK_WR) || ((state_r == ST_RD_BYTE) && !tx_r[7]);

  assign bias_source_select_o = bias_r.bias_source_select;
  assign general_input_two_mode_o = (bias_r.bias_source_select == BIAS_GENERAL_INPUT_TWO);
  always_comb begin
    case (bias_r.bias_source_select)
      BIAS_CM_NEG1: common_mode_level_src_o = CM_NEG1;
      BIAS_CM_NEG2: common_mode_level_src_o = CM_NEG2;
      BIAS_CM_AVG: common_mode_level_src_o = CM_AVG;
      default: common_mode_level_src_o = CM_NONE;
    endcase
  end
  // full-scale code passed through, code 3 unused
  assign full_scale_select_o = bias_r.full_scale_select;
  assign chan1_input_type_o = cfg0_r.chan1_input_type;
  assign chan1_source_select_o = cfg0_r.chan1_source_select;
  // coupling only meaningful for analog sources
  assign chan1_coupling_o = cfg0_r.chan1_coupling && (cfg0_r.chan1_source_select != SRC_PULSE_MIC);
  assign chan1_impedance_o = cfg0_r.chan1_impedance;
  // enable steered by register 108 selector
  assign range_enhancer_en_o = cfg0_r.chan1_range_enhance_enable && !page0_reg108_sel_i;
  assign auto_gain_control_en_o = cfg0_r.chan1_range_enhance_enable && page0_reg108_sel_i;
  assign chan1_gain_field_o = cfg1_r.chan1_gain_field;
  // negative gain honoured only at 10k or 20k
  assign chan1_gain_negative_o = cfg1_r.chan1_gain_polarity &&
    ((cfg0_r.chan1_impedance == IMP_10K) || (cfg0_r.chan1_impedance == IMP_20K));

  sequence seq_bias_write;
    wr_en && (ptr_r == BIAS_FULLSCALE_CONFIG_OFS);
  endsequence
  sequence seq_gain_write;
    wr_en && (ptr_r == CHAN1_GAIN_CONFIG_OFS);
  endsequence

  AST_RESET_ZERO: assert property (@(posedge clk_i) rst_i |=> (bias_r == REG_RESET_VAL) && (cfg1_r == REG_RESET_VAL))
    else $error("config not zero after reset");
  AST_BIAS_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) seq_bias_write |=>
    (bias_source_select_o == $past(shift_r[6:4])) && (full_scale_select_o == $past(shift_r[1:0])))
    else $error("bias write not stored");
  AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !bias_r.rsv7 && (bias_r.rsv32 == 2'h0) && !cfg0_r.rsv1)
    else $error("reserved bit set");
  AST_GAIN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) seq_gain_write |=>
    ({chan1_gain_field_o, cfg1_r.chan1_gain_polarity} == $past(shift_r)))
    else $error("gain write not stored");
  AST_GPI_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    general_input_two_mode_o |-> (common_mode_level_src_o == CM_NONE) && (bias_source_select_o == BIAS_GENERAL_INPUT_TWO))
    else $error("bad general input mode");
  AST_CM_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    (bias_source_select_o == BIAS_CM_AVG) |-> (common_mode_level_src_o == CM_AVG))
    else $error("wrong common-mode source");
  AST_ENH_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
    !(range_enhancer_en_o && auto_gain_control_en_o) && ((range_enhancer_en_o || auto_gain_control_en_o)
    == cfg0_r.chan1_range_enhance_enable))
    else $error("enhancer enable mismatch");
  AST_NEG_GAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    chan1_gain_negative_o |-> (chan1_impedance_o != IMP_2K5))
    else $error("negative gain at low impedance");
  AST_NO_STRAY: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr_en && !rst_i) |=> $stable(bias_r) && $stable(cfg0_r) && $stable(cfg1_r))
    else $error("register changed without write");
  AST_ACK_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(state_r == ST_ACK_WR)) |-> sda_oe_o && $past(scl_fall))
    else $error("write ack not driven");
endmodule : adc_bias_channel_config_regs

// >>> design/adc_cfg_pkg.sv
package adc_cfg_pkg;

  // Two-wire control port target address, arbitrary neutral value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // Register offsets and reset value
  localparam logic [7:0] BIAS_FULLSCALE_CONFIG_OFS = 8'h3B;
  localparam logic [7:0] CHAN1_INPUT_CONFIG_OFS = 8'h3C;
  localparam logic [7:0] CHAN1_GAIN_CONFIG_OFS = 8'h3D;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

  // Bias source codes
  localparam logic [2:0] BIAS_VREF = 3'h0;
  localparam logic [2:0] BIAS_VREF_X1096 = 3'h1;
  localparam logic [2:0] BIAS_CM_NEG1 = 3'h2;
  localparam logic [2:0] BIAS_CM_NEG2 = 3'h3;
  localparam logic [2:0] BIAS_CM_AVG = 3'h4;
  localparam logic [2:0] BIAS_CM_CRUDE = 3'h5;
  localparam logic [2:0] BIAS_SUPPLY = 3'h6;
  localparam logic [2:0] BIAS_GENERAL_INPUT_TWO = 3'h7;

  // Common-mode source encoding on the output
  localparam logic [1:0] CM_NONE = 2'h0;
  localparam logic [1:0] CM_NEG1 = 2'h1;
  localparam logic [1:0] CM_NEG2 = 2'h2;
  localparam logic [1:0] CM_AVG = 2'h3;

  // Full-scale codes
  localparam logic [1:0] FS_2V750 = 2'h0;
  localparam logic [1:0] FS_2V500 = 2'h1;
  localparam logic [1:0] FS_1V375 = 2'h2;
  localparam logic [1:0] FS_RESERVED = 2'h3;

  // Channel source and impedance codes
  localparam logic [1:0] SRC_ANALOG_DIFF = 2'h0;
  localparam logic [1:0] SRC_ANALOG_SE = 2'h1;
  localparam logic [1:0] SRC_PULSE_MIC = 2'h2;
  localparam logic [1:0] IMP_2K5 = 2'h0;
  localparam logic [1:0] IMP_10K = 2'h1;
  localparam logic [1:0] IMP_20K = 2'h2;

  // Highest legal gain code, 42 dB
  localparam logic [6:0] GAIN_MAX_CODE = 7'h54;

  // Serial byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;

  typedef struct packed {
    logic rsv7;
    logic [2:0] bias_source_select;
    logic [1:0] rsv32;
    logic [1:0] full_scale_select;
  } bias_cfg_t;

  typedef struct packed {
    logic chan1_input_type;
    logic [1:0] chan1_source_select;
    logic chan1_coupling;
    logic [1:0] chan1_impedance;
    logic rsv1;
    logic chan1_range_enhance_enable;
  } chan1_cfg0_t;

  typedef struct packed {
    logic [6:0] chan1_gain_field;
    logic chan1_gain_polarity;
  } chan1_cfg1_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR_BYTE,
    ST_ACK_WR,
    ST_RD_BYTE,
    ST_ACK_RD
  } port_state_t;

endpackage : adc_cfg_pkg

// >>> design/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  // Stage one feeds only stage two
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end
endmodule : sync_2ff

// >>> verif/test_adc_bias_channel_config_regs.sv
`timescale 1ns/1ps
module test_adc_bias_channel_config_regs;
  import adc_cfg_pkg::*;

  // Clock, reset and two-wire pins
  logic clk_i;
  logic rst_i;
  logic m_scl;
  logic m_sda;
  logic sel;
  logic sda_i;
  logic sda_o;
  logic sda_oe_o;
  // Decoded controls
  logic [2:0] bias_src;
  logic [1:0] cm_src;
  logic in2_mode;
  logic [1:0] fs;
  logic in_type;
  logic [1:0] src;
  logic cpl;
  logic [1:0] imp;
  logic enh_en;
  logic gctl_en;
  logic [6:0] gain;
  logic gain_neg;
  int n_mismatch = 0;
  int compares = 0;

  // Open-drain wire: the device can only pull low
  assign sda_i = m_sda & (sda_oe_o ? sda_o : 1'b1);

  adc_bias_channel_config_regs #(.DEV_ADDR(DEV_ADDR_DEFAULT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .page0_reg108_sel_i(sel), .bias_source_select_o(bias_src), .common_mode_level_src_o(cm_src),
    .general_input_two_mode_o(in2_mode), .full_scale_select_o(fs), .chan1_input_type_o(in_type),
    .chan1_source_select_o(src), .chan1_coupling_o(cpl), .chan1_impedance_o(imp),
    .range_enhancer_en_o(enh_en), .auto_gain_control_en_o(gctl_en), .chan1_gain_field_o(gain),
    .chan1_gain_negative_o(gain_neg)
  );

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bit; SDA moves only mid-low so the synchroniser sees stable edges
  task automatic bit_x(input logic b, output logic s);
    tick(1);
    m_sda <= b;
    tick(6);
    m_scl <= 1'b1;
    tick(4);
    @(negedge clk_i);
    s = sda_i;
    tick(4);
    m_scl <= 1'b0;
    tick(4);
  endtask : bit_x

  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : byte_tx

  // Also serves as repeated start
  task automatic start_c();
    tick(1);
    m_sda <= 1'b1;
    tick(6);
    m_scl <= 1'b1;
    tick(6);
    m_sda <= 1'b0;
    tick(6);
    m_scl <= 1'b0;
    tick(4);
  endtask : start_c

  task automatic stop_c();
    tick(1);
    m_sda <= 1'b0;
    tick(6);
    m_scl <= 1'b1;
    tick(6);
    m_sda <= 1'b1;
    tick(6);
  endtask : stop_c

  // Write one data byte, or two when n > 1, from pointer ofs; bytes after a refused address are skipped
  task automatic wr_seq(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d0,
                        input logic [7:0] d1, input int n, input logic exp_ack);
    logic ack;
    start_c();
    byte_tx({a, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, exp_ack});
    if (exp_ack) begin
      byte_tx(ofs, ack);
      chk({7'h00, ack}, 8'h01);
      byte_tx(d0, ack);
      chk({7'h00, ack}, 8'h01);
      if (n > 1) begin
        byte_tx(d1, ack);
        chk({7'h00, ack}, 8'h01);
      end
    end
    stop_c();
  endtask : wr_seq

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    wr_seq(DEV_ADDR_DEFAULT, ofs, d, 8'h00, 1, 1'b1);
  endtask : reg_wr

  // Pointer write, repeated start, one byte read, master NACK
  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic ack;
    logic s;
    logic [7:0] d;
    start_c();
    byte_tx({DEV_ADDR_DEFAULT, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    byte_tx(ofs, ack);
    chk({7'h00, ack}, 8'h01);
    start_c();
    byte_tx({DEV_ADDR_DEFAULT, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(1'b1, s);
    stop_c();
    chk(d, exp);
  endtask : reg_rd

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog, well beyond the expected run of about 16k cycles
  initial begin
    #1_500_000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    m_scl = 1'b1;
    m_sda = 1'b1;
    sel = 1'b0;
    tick(16);
    rst_i <= 1'b0;
    tick(4);
    reg_rd(BIAS_FULLSCALE_CONFIG_OFS, REG_RESET_VAL);
    reg_rd(CHAN1_INPUT_CONFIG_OFS, REG_RESET_VAL);
    reg_rd(CHAN1_GAIN_CONFIG_OFS, REG_RESET_VAL);
    chk({1'b0, bias_src, cm_src, fs}, 8'h00);
    // Host keeps reserved bits at zero; they still read back zero
    reg_wr(BIAS_FULLSCALE_CONFIG_OFS, 8'h72);
    reg_rd(BIAS_FULLSCALE_CONFIG_OFS, 8'h72);
    chk({6'h00, fs}, {6'h00, FS_1V375});
    // host uses legal full-scale codes only
    // Every bias code with a rotating full-scale code
    for (int i = 0; i < 8; i++) begin
      reg_wr(BIAS_FULLSCALE_CONFIG_OFS, {1'b0, i[2:0], 2'b00, 2'(i % 3)});
      chk({5'h00, bias_src}, 8'(i));
      chk({6'h00, cm_src}, (i >= 2 && i <= 4) ? 8'(i - 1) : 8'h00);
      chk({7'h00, in2_mode}, {7'h00, i == 7});
      chk({6'h00, fs}, 8'(i % 3));
    end
    // Channel config, enable routed by the selector
    reg_wr(CHAN1_INPUT_CONFIG_OFS, 8'hB9);
    reg_rd(CHAN1_INPUT_CONFIG_OFS, 8'hB9);
    chk({in_type, src, cpl, imp, enh_en, gctl_en}, 8'hBA);
    sel <= 1'b1;
    tick(4);
    chk({in_type, src, cpl, imp, enh_en, gctl_en}, 8'hB9);
    reg_wr(CHAN1_INPUT_CONFIG_OFS, 8'hD5);
    chk({in_type, src, cpl, imp, enh_en, gctl_en}, 8'hC5);
    reg_rd(CHAN1_INPUT_CONFIG_OFS, 8'hD5);
    // Pointer runs on into the gain register
    wr_seq(DEV_ADDR_DEFAULT, CHAN1_INPUT_CONFIG_OFS, 8'h24, {GAIN_MAX_CODE, 1'b1}, 2, 1'b1);
    chk({gain, gain_neg}, {GAIN_MAX_CODE, 1'b1});
    reg_rd(CHAN1_GAIN_CONFIG_OFS, {GAIN_MAX_CODE, 1'b1});
    reg_wr(CHAN1_INPUT_CONFIG_OFS, 8'h20);
    chk({gain, gain_neg}, {GAIN_MAX_CODE, 1'b0});
    reg_wr(CHAN1_GAIN_CONFIG_OFS, 8'hA8);
    reg_rd(CHAN1_GAIN_CONFIG_OFS, 8'hA8);
    // Foreign address ignored, unmapped offset reads zero
    wr_seq(DEV_ADDR_DEFAULT ^ 7'h01, CHAN1_GAIN_CONFIG_OFS, 8'h00, 8'h00, 1, 1'b0);
    reg_rd(CHAN1_GAIN_CONFIG_OFS, 8'hA8);
    reg_wr(8'h3E, 8'h5A);
    reg_rd(8'h3E, UNMAPPED_READ_VAL);
    wrap_up();
  end
endmodule : test_adc_bias_channel_config_regs
